// ---- pkg/prb_consts.svh ----
`ifndef PRB_CONSTS_SVH
`define PRB_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PRB_OFF_CTRL      8'h00
`define PRB_OFF_FLAGS     8'h04
`define PRB_OFF_SIZE      8'h08
`define PRB_OFF_BASE_LO   8'h0C
`define PRB_OFF_BASE_HI   8'h10
`define PRB_OFF_WROFF     8'h14
`define PRB_OFF_DROP_LO   8'h18
`define PRB_OFF_DROP_HI   8'h1C
`define PRB_OFF_THRESH    8'h20
`define PRB_OFF_FILTERS   8'h24
`define PRB_OFF_IPLO_LO   8'h28
`define PRB_OFF_IPLO_HI   8'h2C
`define PRB_OFF_IPHI_LO   8'h30
`define PRB_OFF_IPHI_HI   8'h34
`define PRB_OFF_RDOFF     8'h38
`define PRB_OFF_STATUS    8'h3C
`define PRB_OFF_LIN_LO    8'h40
`define PRB_OFF_LIN_HI    8'h44
`define PRB_OFF_INTERVAL  8'h48

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PRB_CTRL_ENABLE   0
`define PRB_CTRL_RELOAD   1
`define PRB_FLAG_EVENT    0
`define PRB_FLAG_THRESH   31
`define PRB_FILT_IPF      28
`define PRB_SIZE_MSB      27
`define PRB_RAND_LSB      28
`define PRB_RAND_MSB      31
`define PRB_STAT_ACTIVE   0
`define PRB_STAT_EMPTY    1
`define PRB_STAT_BUSY     2

// ----------------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------------
`define PRB_REC_LOG2      5
`define PRB_CNT_W         26
`define PRB_LFSR_SEED     16'hACE1
`define PRB_LFSR_TAPS     16'hB400

`endif

// ---- pkg/prb_pkg.sv ----
package prb_pkg;

  typedef logic [63:0] prb_addr_t;

  typedef enum logic [0:0] {
    PRB_IDLE = 1'b0,
    PRB_WAIT = 1'b1
  } prb_state_e;

endpackage

// ---- rtl/prb_ring_ctrl.sv ----
`timescale 1ns/10ps
// Summary of operation
// - on load, enabled mask is requested flags ANDed with feature config, written back
// - ring size is a 28-bit byte count, rounded down to record multiple
// - each counter reload replaces its low N bits by random bits, N from field
// - on load, base is made linear and kept internally; base field unchanged
// - ring is empty when write offset equals read offset
// - a write offset not below ring size is replaced by zero
// - a write offset not a record multiple is rounded down
// - if advancing would hit read offset, keep offset and bump 64-bit drop count
// - after each store, interrupt if used space reaches the threshold
// - never interrupt while threshold exceeds ring size
// - zero threshold interrupts after every stored record
// - threshold is rounded down to a record multiple
// - threshold ignored when unsupported in config or off in enabled mask
// - an event counts only if it passes the filter field
// - with range filtering, instruction start must be at or above low limit
// - range limits ignored when filter bit is clear or filtering unsupported
// - with range filtering, instruction start must be at or below high limit
// - constant fields load into internal state on enable, reload allowed later
`include "prb_consts.svh"

module prb_ring_ctrl #(
  parameter int REC_LOG2 = `PRB_REC_LOG2
) (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [31:0]         featureConfig,
  input  wire logic                ipRangeSupported,
  input  wire prb_pkg::prb_addr_t  segmentBase,
  input  wire logic                evValid,
  input  wire logic [7:0]          evAttr,
  input  wire prb_pkg::prb_addr_t  evIp,
  output logic                     memWrReq,
  output prb_pkg::prb_addr_t       memWrAddr,
  input  wire logic                memWrAck,
  output logic                     thresholdIrq,
  output logic                     samplerActive
);
  import prb_pkg::*;

  localparam logic [31:0] REC_BYTES = 32'(1) << REC_LOG2;
  localparam int          CW        = `PRB_CNT_W;

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic              enable_q;
  logic [31:0]       flags_q;
  logic [27:0]       ringSizeBytes_q;
  logic [3:0]        random_q;
  prb_addr_t         ringBaseAddress_q;
  logic [31:0]       threshold_q;
  logic [31:0]       filters_q;
  prb_addr_t         ipRangeLow_q;
  prb_addr_t         ipRangeHigh_q;
  logic [31:0]       ringReadOffset_q;
  logic [CW-1:0]     interval_q;
  prb_addr_t         linBase_q;
  logic [31:0]       sizeInt_q;
  logic [31:0]       thrInt_q;
  logic [31:0]       ringWriteOffset_q;
  logic [63:0]       droppedRecordCount_q;
  prb_state_e        state_q;
  logic [CW-1:0]     count_q;
  logic [15:0]       lfsr_q;
  logic [31:0]       prdata_q;
  logic              pslverr_q;
  logic              thresholdIrq_q;
  prb_addr_t         memWrAddr_q;

  logic              apbWrite;
  logic              apbSetup;
  logic              loadNow;
  logic [31:0]       sizeRnd;
  logic [31:0]       wrOffSane;
  logic [31:0]       headSum;
  logic [31:0]       headNext;
  logic              ringFull;
  logic [31:0]       headAfter;
  logic [31:0]       usedSpace;
  logic              thrOn;
  logic              thrFire;
  logic              ipFilterActive;
  logic              inRange;
  logic              filterPass;
  logic              qualified;
  logic              fire;
  logic              storeDone;
  logic [CW-1:0]     randMask;
  logic [CW-1:0]     reloadVal;
  logic [31:0]       readMux;
  logic              readHit;
  assign apbWrite = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  // a write with enable set starts a session, or with reload also set reloads a running one
  assign loadNow  = apbWrite && paddr == `PRB_OFF_CTRL && pwdata[`PRB_CTRL_ENABLE] &&
                    (!enable_q || pwdata[`PRB_CTRL_RELOAD]);

  // ----------------------------------------------------------------------
  // software-owned fields and load-time shadows
  // ----------------------------------------------------------------------
  assign sizeRnd = {4'h0, ringSizeBytes_q[`PRB_SIZE_MSB:REC_LOG2], {REC_LOG2{1'b0}}};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_q          <= 1'b0;
      flags_q           <= 32'h0000_0000;
      ringSizeBytes_q   <= 28'h000_0000;
      random_q          <= 4'h0;
      ringBaseAddress_q <= 64'h0000_0000_0000_0000;
      threshold_q       <= 32'h0000_0000;
      filters_q         <= 32'h0000_0000;
      ipRangeLow_q      <= 64'h0000_0000_0000_0000;
      ipRangeHigh_q     <= 64'h0000_0000_0000_0000;
      ringReadOffset_q  <= 32'h0000_0000;
      interval_q        <= 26'h000_0000;
      linBase_q         <= 64'h0000_0000_0000_0000;
      sizeInt_q         <= 32'h0000_0000;
      thrInt_q          <= 32'h0000_0000;
    end else begin
      if (loadNow) begin
        flags_q   <= flags_q & featureConfig;
        linBase_q <= ringBaseAddress_q + segmentBase;
        sizeInt_q <= sizeRnd;
        thrInt_q  <= {threshold_q[31:REC_LOG2], {REC_LOG2{1'b0}}};
      end
      if (apbWrite) begin
        unique case (paddr)
          `PRB_OFF_CTRL:     enable_q <= pwdata[`PRB_CTRL_ENABLE];
          `PRB_OFF_FLAGS:    flags_q <= pwdata;
          `PRB_OFF_SIZE: begin
            ringSizeBytes_q <= pwdata[`PRB_SIZE_MSB:0];
            random_q        <= pwdata[`PRB_RAND_MSB:`PRB_RAND_LSB];
          end
          `PRB_OFF_BASE_LO:  ringBaseAddress_q[31:0] <= pwdata;
          `PRB_OFF_BASE_HI:  ringBaseAddress_q[63:32] <= pwdata;
          `PRB_OFF_THRESH:   threshold_q <= pwdata;
          `PRB_OFF_FILTERS:  filters_q <= pwdata;
          `PRB_OFF_IPLO_LO:  ipRangeLow_q[31:0] <= pwdata;
          `PRB_OFF_IPLO_HI:  ipRangeLow_q[63:32] <= pwdata;
          `PRB_OFF_IPHI_LO:  ipRangeHigh_q[31:0] <= pwdata;
          `PRB_OFF_IPHI_HI:  ipRangeHigh_q[63:32] <= pwdata;
          `PRB_OFF_RDOFF:    ringReadOffset_q <= pwdata;
          `PRB_OFF_INTERVAL: interval_q <= pwdata[CW-1:0];
          default: ;
        endcase
      end
    end
  end

  assign samplerActive = enable_q;

  // ----------------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------------
  // a set filter bit rejects events carrying that attribute
  assign filterPass     = ~|(evAttr & filters_q[7:0]);
  assign ipFilterActive = filters_q[`PRB_FILT_IPF] & ipRangeSupported;
  assign inRange        = !ipFilterActive ||
                          (evIp >= ipRangeLow_q && evIp <= ipRangeHigh_q);
  assign qualified      = enable_q & flags_q[`PRB_FLAG_EVENT] & evValid & filterPass & inRange;
  // an event at zero while a store is pending is not recorded; counter stays at zero
  assign fire           = qualified && count_q == '0 && state_q == PRB_IDLE;
  assign storeDone      = state_q == PRB_WAIT && memWrAck;

  // ----------------------------------------------------------------------
  // countdown with randomised reload
  // ----------------------------------------------------------------------
  assign randMask  = CW'((32'h1 << random_q) - 32'h1);
  assign reloadVal = (interval_q & ~randMask) | ({10'h000, lfsr_q} & randMask);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_q <= `PRB_LFSR_SEED;
    end else begin
      lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ `PRB_LFSR_TAPS) : (lfsr_q >> 1);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 26'h000_0000;
    end else if (loadNow || fire) begin
      count_q <= reloadVal;
    end else if (qualified && count_q != '0) begin
      count_q <= count_q - CW'(1);
    end
  end

  // ----------------------------------------------------------------------
  // store sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q     <= PRB_IDLE;
      memWrAddr_q <= 64'h0000_0000_0000_0000;
    end else begin
      unique case (state_q)
        PRB_IDLE: begin
          if (fire) begin
            state_q     <= PRB_WAIT;
            memWrAddr_q <= linBase_q + {32'h0000_0000, ringWriteOffset_q};
          end
        end
        PRB_WAIT: begin
          if (memWrAck) begin
            state_q <= PRB_IDLE;
          end
        end
      endcase
    end
  end

  assign memWrReq  = state_q == PRB_WAIT;
  assign memWrAddr = memWrAddr_q;

  // ----------------------------------------------------------------------
  // ring offsets, overflow and threshold
  // ----------------------------------------------------------------------
  always_comb begin
    wrOffSane = 32'h0000_0000;
    if (ringWriteOffset_q < sizeRnd) begin
      wrOffSane = {ringWriteOffset_q[31:REC_LOG2], {REC_LOG2{1'b0}}};
    end
  end

  assign headSum   = ringWriteOffset_q + REC_BYTES;
  assign headNext  = (headSum >= sizeInt_q) ? 32'h0000_0000 : headSum;
  assign ringFull  = headNext == ringReadOffset_q;
  assign headAfter = ringFull ? ringWriteOffset_q : headNext;
  // modulo form; correct only while the read offset stays below the size
  assign usedSpace = (headAfter >= ringReadOffset_q) ? headAfter - ringReadOffset_q :
                     headAfter + sizeInt_q - ringReadOffset_q;
  assign thrOn     = flags_q[`PRB_FLAG_THRESH] & featureConfig[`PRB_FLAG_THRESH];
  assign thrFire   = thrOn && !(threshold_q > sizeInt_q) && usedSpace >= thrInt_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ringWriteOffset_q    <= 32'h0000_0000;
      droppedRecordCount_q <= 64'h0000_0000_0000_0000;
    end else begin
      if (loadNow) begin
        ringWriteOffset_q <= wrOffSane;
      end else if (storeDone) begin
        if (ringFull) begin
          droppedRecordCount_q <= droppedRecordCount_q + 64'h1;
        end else begin
          ringWriteOffset_q <= headNext;
        end
      end else if (apbWrite && !enable_q) begin
        if (paddr == `PRB_OFF_WROFF) ringWriteOffset_q <= pwdata;
        if (paddr == `PRB_OFF_DROP_LO) droppedRecordCount_q[31:0] <= pwdata;
        if (paddr == `PRB_OFF_DROP_HI) droppedRecordCount_q[63:32] <= pwdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      thresholdIrq_q <= 1'b0;
    end else begin
      thresholdIrq_q <= storeDone & thrFire;
    end
  end

  assign thresholdIrq = thresholdIrq_q;

  // ----------------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------------
  always_comb begin
    readHit = 1'b1;
    readMux = 32'h0000_0000;
    unique case (paddr)
      `PRB_OFF_CTRL:     readMux = {31'h0, enable_q};
      `PRB_OFF_FLAGS:    readMux = flags_q;
      `PRB_OFF_SIZE:     readMux = {random_q, ringSizeBytes_q};
      `PRB_OFF_BASE_LO:  readMux = ringBaseAddress_q[31:0];
      `PRB_OFF_BASE_HI:  readMux = ringBaseAddress_q[63:32];
      `PRB_OFF_WROFF:    readMux = ringWriteOffset_q;
      `PRB_OFF_DROP_LO:  readMux = droppedRecordCount_q[31:0];
      `PRB_OFF_DROP_HI:  readMux = droppedRecordCount_q[63:32];
      `PRB_OFF_THRESH:   readMux = threshold_q;
      `PRB_OFF_FILTERS:  readMux = filters_q;
      `PRB_OFF_IPLO_LO:  readMux = ipRangeLow_q[31:0];
      `PRB_OFF_IPLO_HI:  readMux = ipRangeLow_q[63:32];
      `PRB_OFF_IPHI_LO:  readMux = ipRangeHigh_q[31:0];
      `PRB_OFF_IPHI_HI:  readMux = ipRangeHigh_q[63:32];
      `PRB_OFF_RDOFF:    readMux = ringReadOffset_q;
      `PRB_OFF_STATUS:   readMux = {29'h0, memWrReq,
                                    ringWriteOffset_q == ringReadOffset_q, enable_q};
      `PRB_OFF_LIN_LO:   readMux = linBase_q[31:0];
      `PRB_OFF_LIN_HI:   readMux = linBase_q[63:32];
      `PRB_OFF_INTERVAL: readMux = {6'h00, interval_q};
      default:           readHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apbSetup) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : readMux;
      pslverr_q <= !readHit;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = psel & penable;
  assign pslverr = pslverr_q & psel & penable;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_flags_masked: assert property (@(posedge clock) disable iff (!rst_b)
    loadNow |=> (flags_q & ~$past(featureConfig)) == 32'h0)
    else $error("enabled mask holds an unsupported feature");
  a_random_bits: assert property (@(posedge clock) disable iff (!rst_b)
    (fire || loadNow) |=> (count_q & ~$past(randMask)) == ($past(interval_q) & ~$past(randMask)))
    else $error("reload upper bits differ from interval");
  a_load_offset: assert property (@(posedge clock) disable iff (!rst_b)
    (loadNow && sizeRnd != 32'h0) |=> ringWriteOffset_q < sizeInt_q &&
                                      ringWriteOffset_q[REC_LOG2-1:0] == '0)
    else $error("loaded write offset out of range or unaligned");
  a_drop_count: assert property (@(posedge clock) disable iff (!rst_b)
    (storeDone && ringFull && !loadNow) |=>
      droppedRecordCount_q == $past(droppedRecordCount_q) + 64'h1 &&
      ringWriteOffset_q == $past(ringWriteOffset_q))
    else $error("full ring not handled as a drop");
  a_offset_step: assert property (@(posedge clock) disable iff (!rst_b)
    (storeDone && !ringFull && !loadNow) |=> ringWriteOffset_q == 32'h0 ||
      ringWriteOffset_q == $past(ringWriteOffset_q) + REC_BYTES)
    else $error("write offset advanced by a wrong step");
  a_thresh_over: assert property (@(posedge clock) disable iff (!rst_b)
    (storeDone && threshold_q > sizeInt_q) |=> !thresholdIrq)
    else $error("interrupt with threshold above ring size");
  a_thresh_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (storeDone && thrOn && threshold_q == 32'h0) |=> thresholdIrq ##1 !thresholdIrq)
    else $error("zero threshold did not interrupt once per record");
  a_thresh_off: assert property (@(posedge clock) disable iff (!rst_b)
    !thrOn |=> !thresholdIrq)
    else $error("interrupt while threshold disabled");
  a_range_reject: assert property (@(posedge clock) disable iff (!rst_b)
    (evValid && ipFilterActive && (evIp < ipRangeLow_q || evIp > ipRangeHigh_q)) |-> !qualified)
    else $error("out of range instruction counted");
  a_filter_reject: assert property (@(posedge clock) disable iff (!rst_b)
    (evValid && (evAttr & filters_q[7:0]) != 8'h0) |-> !qualified)
    else $error("filtered event counted");
  a_store_hold: assert property (@(posedge clock) disable iff (!rst_b)
    (memWrReq && !memWrAck) |=> memWrReq && $stable(memWrAddr))
    else $error("store request dropped before ack");
endmodule

// ---- test/prb_mem_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// ring memory stand-in: accepts each record store after a chosen lag
// ----------------------------------------------------------------------
module prb_mem_model (
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                memWrReq,
  input  wire prb_pkg::prb_addr_t  memWrAddr,
  input  wire logic [3:0]          lag,
  output logic                     memWrAck,
  output prb_pkg::prb_addr_t       lastAddr
);
  import prb_pkg::*;

  logic [3:0] waitCnt_q;

  // one pulse per request; the cycle after a pulse never acks again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      memWrAck  <= 1'b0;
      waitCnt_q <= 4'h0;
    end else if (memWrReq && !memWrAck && waitCnt_q == lag) begin
      memWrAck  <= 1'b1;
      waitCnt_q <= 4'h0;
    end else begin
      memWrAck  <= 1'b0;
      waitCnt_q <= (memWrReq && !memWrAck) ? waitCnt_q + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastAddr <= '0;
    end else if (memWrReq && memWrAck) begin
      lastAddr <= memWrAddr;
    end
  end
endmodule

// ---- test/prb_ring_ctrl_tb.sv ----
`timescale 1ns/10ps
`include "prb_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t value %0h expected %0h", $time, (a), (e)); end end

module prb_ring_ctrl_tb;
  import prb_pkg::*;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, evAttr;
  logic [31:0] pwdata, prdata, featureConfig, rdat;
  logic        ipRangeSupported, evValid, memWrReq, memWrAck, thresholdIrq, samplerActive;
  logic        rerr;
  logic [3:0]  lag;
  prb_addr_t   segmentBase, evIp, memWrAddr, lastAddr;
  int          mismatches, compares, stores, irqs;
  // software keeps the ring at least 32 x min records x 32 bytes
  localparam int MIN_RECS = 1;

  prb_ring_ctrl prb_ring_ctrl_inst (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .featureConfig(featureConfig),
    .ipRangeSupported(ipRangeSupported), .segmentBase(segmentBase), .evValid(evValid),
    .evAttr(evAttr), .evIp(evIp), .memWrReq(memWrReq), .memWrAddr(memWrAddr),
    .memWrAck(memWrAck), .thresholdIrq(thresholdIrq), .samplerActive(samplerActive));

  prb_mem_model prb_mem_model_inst (.clock(clock), .rst_b(rst_b), .memWrReq(memWrReq),
    .memWrAddr(memWrAddr), .lag(lag), .memWrAck(memWrAck), .lastAddr(lastAddr));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (memWrReq === 1'b1 && memWrAck === 1'b1) stores <= stores + 1;
    if (thresholdIrq === 1'b1) irqs <= irqs + 1;
  end

  // ----------------------------------------------------------------------
  // bus and event helpers
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no wait-state count assumed; only the watchdog ends this wait
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic ev(input logic [7:0] at, input prb_addr_t ip, input int st, input int iq,
                    input prb_addr_t ad = '0);
    int s0, i0;
    s0 = stores; i0 = irqs;
    evAttr <= at; evIp <= ip; evValid <= 1'b1;
    @(posedge clock);
    evValid <= 1'b0;
    repeat (2) @(posedge clock);
    while (memWrReq === 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
    `CHK(stores - s0, st)
    `CHK(irqs - i0, iq)
    if (st == 1) `CHK(lastAddr, ad)
  endtask

  // ring 1040 B (rounds to 1024), base 0x2000 page aligned, upper base zero
  task automatic load(input logic [31:0] wo, rd, th, fl, cf, fi = 32'h0);
    featureConfig <= cf;
    apb(1'b1, `PRB_OFF_CTRL, 32'h0);
    apb(1'b1, `PRB_OFF_SIZE, 32'h0000_0410);
    apb(1'b1, `PRB_OFF_BASE_LO, 32'h0000_2000);
    apb(1'b1, `PRB_OFF_BASE_HI, 32'h0);
    apb(1'b1, `PRB_OFF_WROFF, wo);
    apb(1'b1, `PRB_OFF_RDOFF, rd);
    apb(1'b1, `PRB_OFF_THRESH, th);
    apb(1'b1, `PRB_OFF_FILTERS, fi);
    apb(1'b1, `PRB_OFF_INTERVAL, 32'h0);
    apb(1'b1, `PRB_OFF_FLAGS, fl);
    apb(1'b1, `PRB_OFF_CTRL, 32'h1);
  endtask

  task finish_test;
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_idle;
    `CHK(samplerActive, 1'b0)
    apb(1'b0, `PRB_OFF_STATUS);
    `CHK(rdat, 32'h0000_0002)
    apb(1'b0, 8'h80);
    `CHK(rerr, 1'b1)
  endtask

  task automatic t_wrap_drop;
    lag <= 4'h3;
    load(32'd1000, 32'd64, 32'h0, 32'hFFFF_FFFF, 32'h8000_0001);
    `CHK(samplerActive, 1'b1)
    apb(1'b0, `PRB_OFF_FLAGS);
    `CHK(rdat, 32'h8000_0001)
    apb(1'b0, `PRB_OFF_LIN_LO);
    `CHK(rdat, 32'h0000_3000)
    apb(1'b0, `PRB_OFF_BASE_LO);
    `CHK(rdat, 32'h0000_2000)
    apb(1'b0, `PRB_OFF_WROFF);
    `CHK(rdat, 32'd992)
    ev(8'h0, 64'h0, 1, 1, 64'h33E0);
    apb(1'b0, `PRB_OFF_WROFF);
    `CHK(rdat, 32'h0)
    ev(8'h0, 64'h0, 1, 1, 64'h3000);
    ev(8'h0, 64'h0, 1, 1, 64'h3020);
    apb(1'b0, `PRB_OFF_WROFF);
    `CHK(rdat, 32'd32)
    apb(1'b0, `PRB_OFF_DROP_LO);
    `CHK(rdat, 32'h1)
    apb(1'b1, `PRB_OFF_RDOFF, 32'd32);
    apb(1'b0, `PRB_OFF_STATUS);
    `CHK(rdat[`PRB_STAT_EMPTY], 1'b1)
    lag <= 4'h0;
  endtask

  task automatic t_threshold;
    load(32'd2000, 32'h0, 32'd72, 32'hFFFF_FFFF, 32'h8000_0001);
    apb(1'b0, `PRB_OFF_WROFF);
    `CHK(rdat, 32'h0)
    ev(8'h0, 64'h0, 1, 0, 64'h3000);
    ev(8'h0, 64'h0, 1, 1, 64'h3020);
    load(32'h0, 32'h0, 32'd2000, 32'hFFFF_FFFF, 32'h8000_0001);
    ev(8'h0, 64'h0, 1, 0, 64'h3000);
    load(32'h0, 32'h0, 32'h0, 32'h0000_0001, 32'h8000_0001);
    ev(8'h0, 64'h0, 1, 0, 64'h3000);
    load(32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0000_0001);
    apb(1'b0, `PRB_OFF_FLAGS);
    `CHK(rdat, 32'h0000_0001)
    ev(8'h0, 64'h0, 1, 0, 64'h3000);
  endtask

  task automatic t_filters;
    apb(1'b1, `PRB_OFF_IPLO_LO, 32'h500);
    apb(1'b1, `PRB_OFF_IPLO_HI, 32'h0);
    apb(1'b1, `PRB_OFF_IPHI_LO, 32'h600);
    apb(1'b1, `PRB_OFF_IPHI_HI, 32'h0);
    load(32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h8000_0001, 32'h1000_0001);
    ev(8'h01, 64'h550, 0, 0);
    ev(8'h02, 64'h550, 1, 1, 64'h3000);
    ev(8'h00, 64'h4FF, 0, 0);
    ev(8'h00, 64'h500, 1, 1, 64'h3020);
    ev(8'h00, 64'h600, 1, 1, 64'h3040);
    ev(8'h00, 64'h601, 0, 0);
    ipRangeSupported <= 1'b0;
    ev(8'h00, 64'h700, 1, 1, 64'h3060);
    ipRangeSupported <= 1'b1;
  endtask

  // interval 2 with no random bits: two events count down, the third stores
  task automatic t_interval;
    load(32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h8000_0001);
    apb(1'b1, `PRB_OFF_INTERVAL, 32'h2);
    apb(1'b1, `PRB_OFF_CTRL, 32'h3);
    ev(8'h0, 64'h0, 0, 0);
    ev(8'h0, 64'h0, 0, 0);
    ev(8'h0, 64'h0, 1, 1, 64'h3000);
    // one random bit: reload is 2 or 3, so two events never store a record
    apb(1'b1, `PRB_OFF_SIZE, 32'h1000_0410);
    apb(1'b0, `PRB_OFF_SIZE);
    `CHK(rdat, 32'h1000_0410)
    apb(1'b1, `PRB_OFF_CTRL, 32'h3);
    ev(8'h0, 64'h0, 0, 0);
    ev(8'h0, 64'h0, 0, 0);
  endtask

  initial begin
    rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; featureConfig = 32'h8000_0001; ipRangeSupported = 1'b1;
    segmentBase = 64'h1000; evValid = 1'b0; evAttr = 8'h00; evIp = '0; lag = 4'h0;
    mismatches = 0; compares = 0; stores = 0; irqs = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_idle();
    t_wrap_drop();
    t_threshold();
    t_filters();
    t_interval();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    finish_test();
  end
endmodule
